// [rtl/cms_pkg.sv]
package cms_pkg;

  // Register byte offsets
  localparam logic [7:0] CMS_OFS_CTRL = 8'h00;
  localparam logic [7:0] CMS_OFS_CMD = 8'h04;
  localparam logic [7:0] CMS_OFS_LOAD = 8'h08;
  localparam logic [7:0] CMS_OFS_HOLD = 8'h0c;
  localparam logic [7:0] CMS_OFS_COUNT = 8'h10;
  localparam logic [7:0] CMS_OFS_STATUS = 8'h14;

  // Field positions
  localparam int CMS_CTRL_MODE_LSB = 0;
  localparam int CMS_CTRL_TOGGLE_BIT = 4;
  localparam int CMS_CMD_ARM_BIT = 0;
  localparam int CMS_CMD_DISARM_BIT = 1;

  // Reset values
  localparam logic [15:0] CMS_LOAD_RST = 16'h0000;
  localparam logic [15:0] CMS_HOLD_RST = 16'h0000;
  localparam logic [3:0] CMS_MODE_RST = 4'h0;

  // Counting modes, as written to the mode field
  localparam logic [3:0] CMS_M_RATE = 4'h0;
  localparam logic [3:0] CMS_M_RATE_GATED = 4'h1;
  localparam logic [3:0] CMS_M_ONESHOT = 4'h2;
  localparam logic [3:0] CMS_M_DLY_SW = 4'h3;
  localparam logic [3:0] CMS_M_DLY_GATED = 4'h4;
  localparam logic [3:0] CMS_M_DLY_HWSTROBE = 4'h5;
  localparam logic [3:0] CMS_M_DUTY = 4'h6;
  localparam logic [3:0] CMS_M_DUTY_GATED = 4'h7;
  localparam logic [3:0] CMS_M_DLY_HWONESHOT = 4'h8;
  localparam logic [3:0] CMS_M_RETRIG_LVL = 4'h9;
  localparam logic [3:0] CMS_M_RETRIG_EDGE = 4'ha;
  localparam logic [3:0] CMS_M_SYNC_RATE = 4'hb;
  localparam logic [3:0] CMS_M_RETRIG_ONESHOT = 4'hc;
  localparam logic [3:0] CMS_M_GATE_SEL = 4'hd;

  // Mode groups, one bit per mode code
  localparam logic [15:0] CMS_SET_LVL_GATED = 16'h0a92;
  localparam logic [15:0] CMS_SET_EDGE_START = 16'h1524;
  localparam logic [15:0] CMS_SET_LVL_START = 16'h0200;
  localparam logic [15:0] CMS_SET_TWO_PHASE = 16'h0138;
  localparam logic [15:0] CMS_SET_ALTERNATE = 16'h00c0;
  localparam logic [15:0] CMS_SET_REPEAT = 16'h0803;
  localparam logic [15:0] CMS_SET_REARM = 16'h1104;

  // Sequencer states
  typedef enum logic [2:0] {
    CMS_ST_IDLE = 3'b001,
    CMS_ST_WAIT = 3'b010,
    CMS_ST_RUN = 3'b100
  } cms_state_t;

  // APB request and answer
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } cms_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } cms_apb_rsp_t;

endpackage : cms_pkg

// [rtl/cms_counter_mode_sequencer.sv]
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/100ps
module cms_counter_mode_sequencer (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // APB slave
  input wire cms_pkg::cms_apb_req_t apb_req_i,
  output cms_pkg::cms_apb_rsp_t apb_rsp_o,
  // Counter pins
  input wire logic gate_i,
  input wire logic src_i,
  output logic out_o,
  output logic terminal_count_event_o
);
  import cms_pkg::*;

  // Mode group lookup
  function automatic logic in_set(input logic [3:0] mode, input logic [15:0] set);
    in_set = set[mode];
  endfunction : in_set

  cms_state_t state_q, state_d;
  logic [3:0] mode_q;
  logic tog_q;
  logic [15:0] load_q, hold_q, hold_d, count_q, count_d;
  logic phase_q, phase_d, pend_q, pend_d, skip_q, skip_d;
  logic out_q, out_d, tc_q, gate_q, src_q;
  logic [31:0] prdata_q;

  // APB decode
  wire logic setup = apb_req_i.psel & ~apb_req_i.penable;
  wire logic access = apb_req_i.psel & apb_req_i.penable;
  wire logic wr = access & apb_req_i.pwrite;
  wire logic [7:0] adr = apb_req_i.paddr;
  wire logic [31:0] wd = apb_req_i.pwdata;
  wire logic hit_ctrl = adr == CMS_OFS_CTRL;
  wire logic hit_cmd = adr == CMS_OFS_CMD;
  wire logic hit_load = adr == CMS_OFS_LOAD;
  wire logic hit_hold = adr == CMS_OFS_HOLD;
  wire logic hit_count = adr == CMS_OFS_COUNT;
  wire logic hit_stat = adr == CMS_OFS_STATUS;
  wire logic hit = hit_ctrl | hit_cmd | hit_load | hit_hold | hit_count | hit_stat;
  wire logic arm_cmd = wr & hit_cmd & wd[CMS_CMD_ARM_BIT];
  wire logic disarm_cmd = wr & hit_cmd & wd[CMS_CMD_DISARM_BIT];

  // Read data selection
  wire logic [31:0] rd_data =
    hit_ctrl ? {27'h0, tog_q, mode_q} :
    hit_load ? {16'h0, load_q} :
    hit_hold ? {16'h0, hold_q} :
    hit_count ? {16'h0, count_q} :
    hit_stat ? {28'h0, out_q, phase_q, state_q == CMS_ST_RUN, state_q != CMS_ST_IDLE} :
    32'h0;

  // APB answer; zero wait states, error on unmapped address
  assign apb_rsp_o.prdata = prdata_q;
  assign apb_rsp_o.pready = 1'b1;
  assign apb_rsp_o.pslverr = access & ~hit;

  // Mode classification
  wire logic lvl_gated = in_set(mode_q, CMS_SET_LVL_GATED);
  wire logic edge_start = in_set(mode_q, CMS_SET_EDGE_START);
  wire logic lvl_start = in_set(mode_q, CMS_SET_LVL_START);
  wire logic two_phase = in_set(mode_q, CMS_SET_TWO_PHASE);
  wire logic alternate = in_set(mode_q, CMS_SET_ALTERNATE);
  wire logic repeat_ld = in_set(mode_q, CMS_SET_REPEAT);
  wire logic rearm = in_set(mode_q, CMS_SET_REARM);
  wire logic gate_sel = mode_q == CMS_M_GATE_SEL;

  // Pin edges and counting step
  wire logic gate_rise = gate_i & ~gate_q;
  wire logic src_rise = src_i & ~src_q;
  wire logic running = state_q == CMS_ST_RUN;
  wire logic gate_ok = ~lvl_gated | gate_i;
  wire logic step = running & gate_ok & src_rise;
  wire logic at_end = count_q <= 16'h0001;
  wire logic tc = step & ~pend_q & ~skip_q & at_end;
  wire logic start_ok = edge_start ? gate_rise : (lvl_start & gate_i);

  // Final terminal count of the sequence
  wire logic last = (two_phase | gate_sel) ? phase_q : ~(alternate | repeat_ld);
  // Reload source at a terminal count
  wire logic from_hold = gate_sel ? gate_i : ((two_phase | alternate) & ~phase_q);
  wire logic [15:0] reload = from_hold ? hold_q : load_q;

  // Sequencer next state
  always_comb begin
    state_d = state_q;
    count_d = count_q;
    phase_d = phase_q;
    pend_d = pend_q;
    skip_d = skip_q;
    hold_d = hold_q;
    out_d = tog_q ? out_q : 1'b0;
    if (wr & hit_hold) begin
      hold_d = wd[15:0];
    end
    unique case (state_q)
      CMS_ST_IDLE: begin
      end
      CMS_ST_WAIT: begin
        if (start_ok) begin
          state_d = CMS_ST_RUN;
        end
      end
      CMS_ST_RUN: begin
        // Source edge: pending reload, skip, or decrement
        if (step) begin
          if (pend_q) begin
            count_d = load_q;
            pend_d = 1'b0;
          end else if (skip_q) begin
            skip_d = 1'b0;
          end else if (!at_end) begin
            count_d = count_q - 16'h0001;
          end
        end
        if (tc) begin
          // Terminal count reload and sequencing
          out_d = tog_q ? ~out_q : 1'b1;
          count_d = reload;
          phase_d = ~phase_q;
          if (last) begin
            phase_d = 1'b0;
            count_d = gate_sel ? reload : load_q;
            state_d = rearm ? CMS_ST_WAIT : CMS_ST_IDLE;
          end
        end else if (gate_rise) begin
          // Gate events while running; free modes ignore the gate
          unique case (mode_q)
            CMS_M_RETRIG_LVL: begin
              hold_d = count_q;
              pend_d = 1'b1;
            end
            CMS_M_RETRIG_EDGE: begin
              pend_d = 1'b1;
            end
            CMS_M_SYNC_RATE: begin
              count_d = load_q;
              skip_d = 1'b1;
            end
            CMS_M_RETRIG_ONESHOT: begin
              hold_d = count_q;
              count_d = load_q;
            end
            default: begin
            end
          endcase
        end
      end
      default: begin
        state_d = CMS_ST_IDLE;
      end
    endcase
    // Commands override the sequence
    if (disarm_cmd) begin
      state_d = CMS_ST_IDLE;
      pend_d = 1'b0;
      skip_d = 1'b0;
    end else if (arm_cmd) begin
      state_d = (edge_start | lvl_start) ? CMS_ST_WAIT : CMS_ST_RUN;
      count_d = load_q;
      phase_d = 1'b0;
      pend_d = 1'b0;
      skip_d = 1'b0;
    end
  end

  // Software registers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      mode_q <= CMS_MODE_RST;
      tog_q <= 1'b0;
      load_q <= CMS_LOAD_RST;
      prdata_q <= 32'h0;
    end else begin
      if (wr & hit_ctrl) begin
        mode_q <= wd[CMS_CTRL_MODE_LSB +: 4];
        tog_q <= wd[CMS_CTRL_TOGGLE_BIT];
      end
      if (wr & hit_load) begin
        load_q <= wd[15:0];
      end
      if (setup) begin
        prdata_q <= rd_data;
      end
    end
  end

  // Sequencer registers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_q <= CMS_ST_IDLE;
      count_q <= CMS_LOAD_RST;
      hold_q <= CMS_HOLD_RST;
      phase_q <= 1'b0;
      pend_q <= 1'b0;
      skip_q <= 1'b0;
      out_q <= 1'b0;
      tc_q <= 1'b0;
      gate_q <= 1'b0;
      src_q <= 1'b0;
    end else begin
      state_q <= state_d;
      count_q <= count_d;
      hold_q <= hold_d;
      phase_q <= phase_d;
      pend_q <= pend_d;
      skip_q <= skip_d;
      out_q <= out_d;
      tc_q <= tc;
      gate_q <= gate_i;
      src_q <= src_i;
    end
  end

  // Pin outputs
  assign out_o = out_q;
  assign terminal_count_event_o = tc_q;

  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  wire logic quiet = ~arm_cmd & ~disarm_cmd;

  property p_rate_reload;
    quiet && tc && mode_q == CMS_M_RATE |=> running && count_q == $past(load_q);
  endproperty
  a_rate_reload: assert property (p_rate_reload) else $error("rate reload wrong");

  property p_rate_nogate;
    quiet && step && mode_q == CMS_M_RATE && !at_end && !pend_q && !skip_q
      |=> count_q == $past(count_q) - 16'h0001;
  endproperty
  a_rate_nogate: assert property (p_rate_nogate) else $error("rate step lost");

  property p_toggle;
    tc && tog_q |=> out_q != $past(out_q);
  endproperty
  a_toggle: assert property (p_toggle) else $error("output did not toggle");

  property p_gated_pause;
    quiet && running && lvl_gated && !gate_i && !gate_rise && !(wr && hit_hold)
      |=> $stable(count_q) && $stable(hold_q);
  endproperty
  a_gated_pause: assert property (p_gated_pause) else $error("gated count moved");

  property p_oneshot_rearm;
    quiet && tc && rearm && last |=> state_q == CMS_ST_WAIT && count_q == $past(load_q);
  endproperty
  a_oneshot_rearm: assert property (p_oneshot_rearm) else $error("one-shot rearm");

  property p_dly_hold;
    quiet && tc && two_phase && !phase_q |=> phase_q && count_q == $past(hold_q) && running;
  endproperty
  a_dly_hold: assert property (p_dly_hold) else $error("no hold phase");

  property p_dly_end;
    quiet && tc && mode_q == CMS_M_DLY_SW && phase_q |=> state_q == CMS_ST_IDLE && !phase_q;
  endproperty
  a_dly_end: assert property (p_dly_end) else $error("delayed pulse not ended");

  property p_duty_alt;
    quiet && tc && alternate |=> running && phase_q != $past(phase_q);
  endproperty
  a_duty_alt: assert property (p_duty_alt) else $error("duty did not alternate");

  property p_retrig_save;
    quiet && running && !tc && gate_rise && mode_q == CMS_M_RETRIG_ONESHOT
      |=> hold_q == $past(count_q) && count_q == $past(load_q);
  endproperty
  a_retrig_save: assert property (p_retrig_save) else $error("retrigger save");

  property p_sync_skip;
    quiet && running && !tc && gate_rise && mode_q == CMS_M_SYNC_RATE
      |=> skip_q && count_q == $past(load_q);
  endproperty
  a_sync_skip: assert property (p_sync_skip) else $error("sync reload wrong");

  property p_gate_sel;
    quiet && tc && gate_sel && gate_i |=> count_q == $past(hold_q);
  endproperty
  a_gate_sel: assert property (p_gate_sel) else $error("gate select reload");

  property p_disarm;
    disarm_cmd |=> state_q == CMS_ST_IDLE ##1 state_q == CMS_ST_IDLE || $past(arm_cmd);
  endproperty
  a_disarm: assert property (p_disarm) else $error("disarm ignored");

  c_rate_tc: cover property (tc && mode_q == CMS_M_RATE);
  c_dly_done: cover property (tc && two_phase && phase_q);
  c_retrig: cover property (running && gate_rise && mode_q == CMS_M_RETRIG_LVL);
  c_gate_sel: cover property (tc && gate_sel && gate_i);

endmodule : cms_counter_mode_sequencer

// [tb/cms_host_model.sv]
`timescale 1ns/100ps
module cms_host_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // APB master side
  output cms_pkg::cms_apb_req_t req_o,
  input wire cms_pkg::cms_apb_rsp_t rsp_i,
  // Counter pins
  output logic gate_o,
  output logic src_o,
  output logic tmo_o
);
  import cms_pkg::*;

  // Idle levels from time zero
  initial begin
    req_o = '0;
    gate_o = 1'b0;
    src_o = 1'b0;
    tmo_o = 1'b0;
  end

  // One APB transfer; request held until pready is sampled
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    int k;
    k = 0;
    @(posedge clk_i);
    req_o <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk_i);
    req_o.penable <= 1'b1;
    do begin
      @(posedge clk_i);
      k++;
    end while (rsp_i.pready !== 1'b1 && k < 50);
    r = rsp_i.prdata;
    e = rsp_i.pslverr;
    req_o.psel <= 1'b0;
    req_o.penable <= 1'b0;
    if (k >= 50) tmo_o <= 1'b1;
  endtask : xfer

  // Gate level, set on one edge and held over the next so an edge is seen
  task automatic set_gate(input logic v);
    @(posedge clk_i);
    gate_o <= v;
    @(posedge clk_i);
  endtask : set_gate

  // Count source steps, one clock high and one low; optional gate noise
  task automatic steps(input int n, input logic rg);
    repeat (n) begin
      @(posedge clk_i);
      src_o <= 1'b1;
      if (rg) gate_o <= 1'($urandom % 2);
      @(posedge clk_i);
      src_o <= 1'b0;
    end
    repeat (3) @(posedge clk_i);
  endtask : steps

  // Disarm command that stops a repeating mode
  task automatic disarm(output logic [31:0] r, output logic e);
    xfer(1'b1, CMS_OFS_CMD, 32'h2, r, e);
  endtask : disarm
endmodule : cms_host_model

// [tb/tb.sv]
`timescale 1ns/100ps
module tb;
  import cms_pkg::*;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  cms_apb_req_t req;
  cms_apb_rsp_t rsp;
  logic gate, src, out, tce, tmo, err, o0;
  logic [31:0] rd;
  logic [3:0] tbl [5] = '{4'h0, 4'h3, 4'h6, 4'hd, 4'hd};
  int errors = 0;
  int compares = 0;
  int tcn = 0;
  int c, e, t0, ld, hd, n;

  // Clock
  always #2 clk_i = ~clk_i;

  cms_counter_mode_sequencer dut (.clk_i(clk_i), .srst_i(srst_i), .apb_req_i(req),
    .apb_rsp_o(rsp), .gate_i(gate), .src_i(src), .out_o(out),
    .terminal_count_event_o(tce));
  cms_host_model host (.clk_i(clk_i), .srst_i(srst_i), .req_o(req), .rsp_i(rsp),
    .gate_o(gate), .src_o(src), .tmo_o(tmo));

  // Terminal count pulses seen
  always @(posedge clk_i) begin
    if (tce === 1'b1) tcn <= tcn + 1;
  end

  // Hang guard
  always @(posedge clk_i) begin
    if (tmo === 1'b1) begin
      errors++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    compares++;
    if (s !== x) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, rd, err);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] x);
    host.xfer(1'b0, a, 32'h0, rd, err);
    chk(rd, x);
  endtask : rdchk

  // Program mode, load, hold and toggle, then arm
  task automatic setup(input logic [3:0] m, input int l, input int h, input logic tg);
    host.disarm(rd, err);
    wr(CMS_OFS_CTRL, {27'h0, tg, m});
    wr(CMS_OFS_LOAD, 32'(l));
    wr(CMS_OFS_HOLD, 32'(h));
    wr(CMS_OFS_CMD, 32'h1);
    t0 = tcn;
  endtask : setup

  // Reference count of terminal counts and final count for ungated modes
  function automatic int model(input int m, input int l, input int h, input int k,
                               input int g, output int cnt);
    int cc, ph, arm, tcs;
    cc = l;
    ph = 0;
    arm = 1;
    tcs = 0;
    for (int i = 0; i < k; i++) begin
      if (arm != 0) begin
        if (cc <= 1) begin
          tcs++;
          ph++;
          if (m == 3) cc = (ph == 1) ? h : l;
          else if (m == 6) cc = (ph % 2 == 1) ? h : l;
          else if (m == 13) cc = (g != 0) ? h : l;
          else cc = l;
          if ((m == 3 || m == 13) && ph == 2) arm = 0;
        end else begin
          cc--;
        end
      end
    end
    cnt = cc;
    return tcs;
  endfunction : model

  task automatic end_of_test;
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  // Main sequence
  initial begin
    void'($urandom(16));
    repeat (20) @(posedge clk_i);
    srst_i <= 1'b0;
    rdchk(CMS_OFS_LOAD, 32'h0);
    rdchk(CMS_OFS_HOLD, 32'h0);
    rdchk(CMS_OFS_COUNT, 32'h0);
    rdchk(CMS_OFS_STATUS, 32'h0);
    host.xfer(1'b0, 8'h3c, 32'h0, rd, err);
    chk(32'(err), 32'h1);
    chk(rd, 32'h0);
    $display("test reset done");
    // Ungated modes against the model, toggle output on
    for (int i = 0; i < 5; i++) begin
      ld = 2 + $urandom % 4;
      hd = 2 + $urandom % 4;
      n = 2 * (ld + hd) + 1;
      host.set_gate(1'(i == 4));
      setup(tbl[i], ld, hd, 1'b1);
      o0 = out;
      host.steps(n, 1'(tbl[i] == 4'h0));
      e = model(tbl[i], ld, hd, n, (i == 4) ? 1 : 0, c);
      chk(32'(tcn - t0), 32'(e));
      rdchk(CMS_OFS_COUNT, 32'(c));
      chk(32'(out), 32'(o0 ^ 1'(e % 2)));
      host.disarm(rd, err);
      t0 = tcn;
      host.steps(4, 1'b0);
      chk(32'(tcn - t0), 32'h0);
    end
    $display("test model modes done");
    // Level-gated rate
    host.set_gate(1'b0);
    setup(4'h1, 2, 2, 1'($urandom % 2));
    host.steps(4, 1'b0);
    chk(32'(tcn - t0), 32'h0);
    host.set_gate(1'b1);
    host.steps(4, 1'b0);
    chk(32'(tcn - t0), 32'h2);
    $display("test gated rate done");
    // Non-retriggerable one-shot
    host.set_gate(1'b0);
    setup(4'h2, 2, 2, 1'($urandom % 2));
    host.steps(3, 1'b0);
    chk(32'(tcn - t0), 32'h0);
    host.set_gate(1'b1);
    host.steps(4, 1'b0);
    chk(32'(tcn - t0), 32'h1);
    rdchk(CMS_OFS_COUNT, 32'h2);
    host.set_gate(1'b0);
    host.set_gate(1'b1);
    host.steps(2, 1'b0);
    chk(32'(tcn - t0), 32'h2);
    $display("test one-shot done");
    // Retriggerable one-shot with an early gate edge
    host.set_gate(1'b0);
    setup(4'hc, 4, 0, 1'($urandom % 2));
    host.set_gate(1'b1);
    host.steps(2, 1'b0);
    host.set_gate(1'b0);
    host.set_gate(1'b1);
    rdchk(CMS_OFS_HOLD, 32'h2);
    rdchk(CMS_OFS_COUNT, 32'h4);
    host.steps(4, 1'b0);
    chk(32'(tcn - t0), 32'h1);
    $display("test retrigger done");
    // Gated delayed pulse: paused while gate low, two counts then disarmed
    host.set_gate(1'b0);
    setup(4'h4, 2, 2, 1'($urandom % 2));
    host.steps(3, 1'b0);
    chk(32'(tcn - t0), 32'h0);
    host.set_gate(1'b1);
    host.steps(5, 1'b0);
    chk(32'(tcn - t0), 32'h2);
    host.xfer(1'b0, CMS_OFS_STATUS, 32'h0, rd, err);
    chk(32'(rd[0]), 32'h0);
    // Hardware delayed strobe: one gate edge, later gate activity ignored
    host.set_gate(1'b0);
    setup(4'h5, 2, 2, 1'($urandom % 2));
    host.steps(3, 1'b0);
    chk(32'(tcn - t0), 32'h0);
    host.set_gate(1'b1);
    host.set_gate(1'b0);
    host.steps(5, 1'b1);
    chk(32'(tcn - t0), 32'h2);
    host.set_gate(1'b0);
    host.set_gate(1'b1);
    host.steps(4, 1'b0);
    chk(32'(tcn - t0), 32'h2);
    // Gated duty cycle: load then hold, frozen while gate low
    host.set_gate(1'b0);
    setup(4'h7, 2, 3, 1'($urandom % 2));
    host.steps(3, 1'b0);
    chk(32'(tcn - t0), 32'h0);
    host.set_gate(1'b1);
    host.steps(5, 1'b0);
    chk(32'(tcn - t0), 32'h2);
    host.set_gate(1'b0);
    host.steps(3, 1'b0);
    chk(32'(tcn - t0), 32'h2);
    rdchk(CMS_OFS_COUNT, 32'h2);
    // Hardware delayed one-shot: edge mid-cycle ignored, next edge reruns
    host.set_gate(1'b0);
    setup(4'h8, 2, 3, 1'($urandom % 2));
    host.steps(2, 1'b0);
    chk(32'(tcn - t0), 32'h0);
    host.set_gate(1'b1);
    host.steps(1, 1'b0);
    host.set_gate(1'b0);
    host.set_gate(1'b1);
    host.steps(2, 1'b0);
    rdchk(CMS_OFS_COUNT, 32'h2);
    host.steps(4, 1'b0);
    chk(32'(tcn - t0), 32'h2);
    host.set_gate(1'b0);
    host.set_gate(1'b1);
    host.steps(5, 1'b0);
    chk(32'(tcn - t0), 32'h4);
    // Level retrigger strobe: halt on gate low, save on reassert, reload on the next source edge
    host.set_gate(1'b0);
    setup(4'h9, 3, 0, 1'($urandom % 2));
    host.steps(2, 1'b0);
    chk(32'(tcn - t0), 32'h0);
    host.set_gate(1'b1);
    host.steps(1, 1'b0);
    host.set_gate(1'b0);
    host.steps(2, 1'b0);
    rdchk(CMS_OFS_COUNT, 32'h2);
    host.set_gate(1'b1);
    rdchk(CMS_OFS_HOLD, 32'h2);
    host.steps(1, 1'b0);
    rdchk(CMS_OFS_COUNT, 32'h3);
    host.steps(3, 1'b0);
    chk(32'(tcn - t0), 32'h1);
    host.xfer(1'b0, CMS_OFS_STATUS, 32'h0, rd, err);
    chk(32'(rd[0]), 32'h0);
    // Edge retrigger strobe: early edge reloads on the next source edge
    host.set_gate(1'b0);
    setup(4'ha, 4, 0, 1'($urandom % 2));
    host.set_gate(1'b1);
    host.steps(2, 1'b0);
    host.set_gate(1'b0);
    host.set_gate(1'b1);
    host.steps(1, 1'b0);
    rdchk(CMS_OFS_COUNT, 32'h4);
    host.steps(4, 1'b0);
    chk(32'(tcn - t0), 32'h1);
    host.xfer(1'b0, CMS_OFS_STATUS, 32'h0, rd, err);
    chk(32'(rd[0]), 32'h0);
    // Synchronised rate: inhibited while low, gate rise reloads and skips
    host.set_gate(1'b0);
    setup(4'hb, 3, 0, 1'($urandom % 2));
    host.steps(2, 1'b0);
    chk(32'(tcn - t0), 32'h0);
    host.set_gate(1'b1);
    host.steps(2, 1'b0);
    host.set_gate(1'b0);
    host.set_gate(1'b1);
    rdchk(CMS_OFS_COUNT, 32'h3);
    host.steps(1, 1'b0);
    rdchk(CMS_OFS_COUNT, 32'h3);
    host.steps(1, 1'b0);
    rdchk(CMS_OFS_COUNT, 32'h2);
    host.steps(4, 1'b0);
    chk(32'(tcn - t0), 32'h1);
    host.set_gate(1'b0);
    host.steps(3, 1'b0);
    chk(32'(tcn - t0), 32'h1);
    $display("test gate modes done");
    // Disarm after a gate edge in every mode
    for (int m = 0; m < 14; m++) begin
      host.set_gate(1'b0);
      setup(4'(m), 2 + $urandom % 4, 2, 1'($urandom % 2));
      host.set_gate(1'b1);
      host.disarm(rd, err);
      t0 = tcn;
      host.steps(4, 1'b1);
      chk(32'(tcn - t0), 32'h0);
      host.xfer(1'b0, CMS_OFS_STATUS, 32'h0, rd, err);
      chk(32'(rd[0]), 32'h0);
    end
    $display("test disarm done");
    end_of_test();
  end

  // Overall run limit
  initial begin
    repeat (100000) @(posedge clk_i);
    errors++;
    end_of_test();
  end
endmodule : tb
